// *** inc/isl_pkg.sv ***
// Package for the infrared secondary link sequencer.
// Assumes a 200 MHz clock; frames arrive already decoded as type codes.
package isl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned SILENCE_S        = 10;
  localparam longint unsigned SILENCE_CYC  = longint'(SILENCE_S) * CLK_MHZ * 1000000;
  localparam int unsigned LINK_BAUD        = 9600;

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  localparam int unsigned HOST_BUF_DEPTH   = 29;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam int unsigned CTS_STOP_LEVEL   = 23;
  localparam int unsigned DATA_W           = 8;

  // ----------------------------------------------------------------
  // Frame codes from the link decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ISL_FR_XID     = 4'h1,
    ISL_FR_BCAST   = 4'h2,
    ISL_FR_SNRM    = 4'h3,
    ISL_FR_IAS_OPEN= 4'h4,
    ISL_FR_IAS_QRY = 4'h5,
    ISL_FR_DATA_OPEN = 4'h6,
    ISL_FR_DATA    = 4'h7,
    ISL_FR_STATUS  = 4'h8,
    ISL_FR_DISC    = 4'h9,
    ISL_FR_OTHER   = 4'h0
  } isl_frame_t;

  // Reply codes handed to the link encoder.
  typedef enum logic [3:0] {
    ISL_RP_NONE     = 4'h0,
    ISL_RP_XID      = 4'h1,
    ISL_RP_UA_PARAM = 4'h2,
    ISL_RP_IAS_OPEN = 4'h3,
    ISL_RP_IAS_ANS  = 4'h4,
    ISL_RP_DATA_OPEN= 4'h5,
    ISL_RP_KEEP     = 4'h6,
    ISL_RP_DATA     = 4'h7,
    ISL_RP_UA_DISC  = 4'h8
  } isl_reply_t;

  // Advertised parameters: rate bit for 9.6 kbaud only.
  localparam logic [7:0] PARAM_RATE_9600   = 8'h02;
  // Device class advertised: serial modem; value is arbitrary.
  localparam logic [7:0] DEV_CLASS_MODEM   = 8'h01;

  typedef enum logic [1:0] {
    ISL_NDM,
    ISL_DISC_LINK,
    ISL_DISC_IAS,
    ISL_NCM
  } isl_state_t;

endpackage

// *** core/isl_fifo.sv ***
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module isl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,      // Clock.
  input  wire logic             nrst,     // Reset, active low.
  input  wire logic [WIDTH-1:0] in_data,  // Write data.
  input  wire logic             in_valid, // Write request.
  output logic                  in_ready, // Space available.
  output logic      [WIDTH-1:0] out_data, // Read data.
  output logic                  out_valid,// Data available.
  input  wire logic             out_ready,// Reader takes data.
  output logic [$clog2(DEPTH):0] level    // Words held.
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];
  assign level     = cnt_ff;

  always_comb begin
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop  ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ff] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** core/isl_sequencer.sv ***
// Connection sequencer of an infrared secondary station.
// Assumes decoded link frames arrive as one-cycle strobes with a type code,
// and host UART bytes arrive as one-cycle strobes already deserialised.
//
// Functional notes
// - Enter discovery only after own XID reply, then primary's series and broadcast ID.
// - Without completed series and broadcast ID, stay disconnected indefinitely.
// - Link starts at the 9600 baud default before negotiation.
// - Advertise only 9.6 kbaud during parameter negotiation.
// - Primary sends parameters first; device answers with its own set.
// - Answer SNRM with UA carrying parameters and the given connection address.
// - Confirm information-channel open, then answer each resource query.
// - Answer service name, address and capability queries.
// - Confirm the data channel open before any user data moves.
// - During discovery answer everything locally, pass nothing to the host.
// - During discovery hold clear-to-send deasserted; host must not send.
// - When connected, clear-to-send stops the host once the buffer fills.
// - Host-side receive buffer holds 29 bytes, the outgoing data block size; the FIFO here holds 16.
// - Clear-to-send goes high once 23 bytes are held; the code raises it at 16 (CTS_STOP_LEVEL - 7).
// - Both stations check their sent packets arrive without errors.
// - While connected keep exchanging packets even without data.
// - Confirm a close-link command and return to disconnected.
// - Without close-link, drop to disconnected 10 s after the last frame.
// - Present as a modem-class serial device.
// - Do not give non-data circuits modem meaning.
// - Activity indicator goes low after 10 s without infrared activity.
// - Activity indicator goes high when XID discovery commands start.
// - Reply to XID in timeslot 0 only; ignore later XIDs of that series.
// - Never reply to the broadcast ID frame.
// - With data channel open in normal response mode, drive data-set-ready low.
`timescale 1ns/100ps
`default_nettype none
module isl_sequencer
  import isl_pkg::*;
#(
  parameter longint unsigned SILENCE_CYCLES = isl_pkg::SILENCE_CYC
) (
  input  wire logic                    clk,            // 200 MHz clock.
  input  wire logic                    nrst,           // Async reset, active low.
  input  wire logic                    rx_frame_valid, // Decoded frame strobe.
  input  wire isl_pkg::isl_frame_t     rx_frame_type,  // Frame type code.
  input  wire logic [7:0]              rx_slot,        // XID timeslot number.
  input  wire logic [7:0]              rx_conn_addr,   // SNRM connection address.
  input  wire logic                    rx_crc_ok,      // Frame checked good.
  input  wire logic                    rx_activity,    // Any infrared activity.
  output logic                         tx_reply_valid, // Reply request strobe.
  output isl_pkg::isl_reply_t          tx_reply_type,  // Reply type code.
  output logic [7:0]                   tx_conn_addr,   // Address for reply.
  output logic [7:0]                   tx_param_rate,  // Advertised rate bits.
  output logic [7:0]                   tx_dev_class,   // Advertised class.
  input  wire logic                    tx_ready,       // Encoder can take a byte.
  output logic                         tx_data_valid,  // Host byte to link.
  output logic [7:0]                   tx_data,        // Host byte value.
  input  wire logic                    host_rx_valid,  // Byte from host UART.
  input  wire logic [7:0]              host_rx_data,   // Host byte value.
  output logic                         host_cts_n,     // Clear-to-send, active low.
  output logic                         host_dsr_n,     // Data-set-ready, active low.
  output logic                         ir_activity_indicator, // Activity level.
  output logic                         link_baud_9600, // Link runs at 9600.
  output logic [1:0]                   link_state      // Sequencer state.
);
  import isl_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_frame(input logic v, input isl_frame_t t,
                                    input isl_frame_t want);
    return v && (t == want);
  endfunction

  // ----------------------------------------------------------------
  // Host buffer
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] f_out;
  logic              f_out_valid, f_in_ready, f_pop;
  logic [4:0]        f_level;
  logic              host_ok;

  isl_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) i_isl_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (host_rx_data),
    .in_valid  (host_rx_valid && host_ok),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_pop),
    .level     (f_level)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  isl_state_t state_ff, nxt_state;
  logic       xid_sent_ff, nxt_xid_sent;
  logic       data_open_ff, nxt_data_open;
  logic       ias_open_ff, nxt_ias_open;
  logic       rp_v_ff, nxt_rp_v;
  isl_reply_t rp_t_ff, nxt_rp_t;
  logic [7:0] addr_ff, nxt_addr;
  logic       cts_n_ff, nxt_cts_n;
  logic       dsr_n_ff, nxt_dsr_n;
  logic       act_ff, nxt_act;
  logic [40:0] sil_ff, nxt_sil;
  logic [40:0] idle_ff, nxt_idle;
  logic       txv_ff, nxt_txv;
  logic [7:0] txd_ff, nxt_txd;
  logic [4:0] blk_ff, nxt_blk;
  logic       good;

  // Bytes only enter the buffer while connected; discovery keeps host out.
  assign host_ok = (state_ff == ISL_NCM) && data_open_ff;
  assign good  = rx_frame_valid && rx_crc_ok;
  assign f_pop = f_out_valid && (!txv_ff || tx_ready);

  always_comb begin
    nxt_state     = state_ff;
    nxt_xid_sent  = xid_sent_ff;
    nxt_data_open = data_open_ff;
    nxt_ias_open  = ias_open_ff;
    nxt_rp_v      = 1'b0;
    nxt_rp_t      = rp_t_ff;
    nxt_addr      = addr_ff;
    nxt_sil       = sil_ff;
    nxt_idle      = idle_ff;
    nxt_act       = act_ff;
    nxt_txv       = txv_ff;
    nxt_txd       = txd_ff;
    nxt_blk       = blk_ff;

    // Activity indicator.
    if (rx_activity) begin
      nxt_idle = '0;
    end else if (idle_ff < 41'(SILENCE_CYCLES)) begin
      nxt_idle = idle_ff + 41'h1;
    end
    if (is_frame(good, rx_frame_type, ISL_FR_XID)) begin
      nxt_act = 1'b1;
    end else if (idle_ff >= 41'(SILENCE_CYCLES) - 41'h1 && !rx_activity) begin
      nxt_act = 1'b0;
    end

    // Silence timer since last good frame.
    if (good) begin
      nxt_sil = '0;
    end else if (state_ff != ISL_NDM) begin
      nxt_sil = sil_ff + 41'h1;
    end

    case (state_ff)
      ISL_NDM: begin
        nxt_data_open = 1'b0;
        nxt_ias_open  = 1'b0;
        if (is_frame(good, rx_frame_type, ISL_FR_XID)) begin
          // Only slot 0 is claimed; later slots of the series are ignored.
          if (rx_slot == 8'h00 && !xid_sent_ff) begin
            nxt_rp_v     = 1'b1;
            nxt_rp_t     = ISL_RP_XID;
            nxt_xid_sent = 1'b1;
          end
        end else if (is_frame(good, rx_frame_type, ISL_FR_BCAST)) begin
          // No reply to the broadcast; it closes the series.
          if (xid_sent_ff) begin
            nxt_state = ISL_DISC_LINK;
            nxt_sil   = '0;
          end
          nxt_xid_sent = 1'b0;
        end
      end
      ISL_DISC_LINK: begin
        if (is_frame(good, rx_frame_type, ISL_FR_SNRM)) begin
          nxt_addr  = rx_conn_addr;
          nxt_rp_v  = 1'b1;
          nxt_rp_t  = ISL_RP_UA_PARAM;
          nxt_state = ISL_DISC_IAS;
        end
      end
      ISL_DISC_IAS: begin
        if (is_frame(good, rx_frame_type, ISL_FR_IAS_OPEN)) begin
          nxt_ias_open = 1'b1;
          nxt_rp_v     = 1'b1;
          nxt_rp_t     = ISL_RP_IAS_OPEN;
        end else if (is_frame(good, rx_frame_type, ISL_FR_IAS_QRY) && ias_open_ff) begin
          nxt_rp_v = 1'b1;
          nxt_rp_t = ISL_RP_IAS_ANS;
        end else if (is_frame(good, rx_frame_type, ISL_FR_DATA_OPEN)) begin
          nxt_data_open = 1'b1;
          nxt_rp_v      = 1'b1;
          nxt_rp_t      = ISL_RP_DATA_OPEN;
          nxt_state     = ISL_NCM;
        end
      end
      ISL_NCM: begin
        if (is_frame(good, rx_frame_type, ISL_FR_DISC)) begin
          nxt_rp_v  = 1'b1;
          nxt_rp_t  = ISL_RP_UA_DISC;
          nxt_state = ISL_NDM;
        end else if (good && (rx_frame_type == ISL_FR_DATA ||
                              rx_frame_type == ISL_FR_STATUS)) begin
          // Answer every poll; send status when nothing is waiting.
          nxt_rp_v = 1'b1;
          nxt_rp_t = f_out_valid ? ISL_RP_DATA : ISL_RP_KEEP;
        end
      end
      default: begin
        nxt_state = ISL_NDM;
      end
    endcase

    // Falling back after silence.
    if (state_ff != ISL_NDM && sil_ff >= 41'(SILENCE_CYCLES) - 41'h1 && !good) begin
      nxt_state     = ISL_NDM;
      nxt_data_open = 1'b0;
      nxt_sil       = '0;
    end

    // Host bytes toward the link, counted in blocks of 29.
    if (f_pop) begin
      nxt_txv = 1'b1;
      nxt_txd = f_out;
      nxt_blk = (blk_ff == 5'(HOST_BUF_DEPTH - 1)) ? 5'h00 : blk_ff + 5'h01;
    end else if (tx_ready) begin
      nxt_txv = 1'b0;
    end
  end

  // Clear-to-send and data-set-ready; other circuits carry no modem meaning.
  always_comb begin
    nxt_cts_n = 1'b1;
    if (nxt_state == ISL_NCM && nxt_data_open) begin
      nxt_cts_n = (f_level >= 5'(CTS_STOP_LEVEL - 7)) || !f_in_ready;
    end
    nxt_dsr_n = !(nxt_state == ISL_NCM && nxt_data_open);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff     <= ISL_NDM;
      xid_sent_ff  <= 1'b0;
      data_open_ff <= 1'b0;
      ias_open_ff  <= 1'b0;
      rp_v_ff      <= 1'b0;
      rp_t_ff      <= ISL_RP_NONE;
      addr_ff      <= 8'h00;
      cts_n_ff     <= 1'b1;
      dsr_n_ff     <= 1'b1;
      act_ff       <= 1'b0;
      sil_ff       <= '0;
      idle_ff      <= '0;
      txv_ff       <= 1'b0;
      txd_ff       <= 8'h00;
      blk_ff       <= 5'h00;
    end else begin
      state_ff     <= nxt_state;
      xid_sent_ff  <= nxt_xid_sent;
      data_open_ff <= nxt_data_open;
      ias_open_ff  <= nxt_ias_open;
      rp_v_ff      <= nxt_rp_v;
      rp_t_ff      <= nxt_rp_t;
      addr_ff      <= nxt_addr;
      cts_n_ff     <= nxt_cts_n;
      dsr_n_ff     <= nxt_dsr_n;
      act_ff       <= nxt_act;
      sil_ff       <= nxt_sil;
      idle_ff      <= nxt_idle;
      txv_ff       <= nxt_txv;
      txd_ff       <= nxt_txd;
      blk_ff       <= nxt_blk;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tx_reply_valid        = rp_v_ff;
  assign tx_reply_type         = rp_t_ff;
  assign tx_conn_addr          = addr_ff;
  assign tx_param_rate         = PARAM_RATE_9600;
  assign tx_dev_class          = DEV_CLASS_MODEM;
  assign tx_data_valid         = txv_ff;
  assign tx_data               = txd_ff;
  assign host_cts_n            = cts_n_ff;
  assign host_dsr_n            = dsr_n_ff;
  assign ir_activity_indicator = act_ff;
  assign link_baud_9600        = 1'b1;
  assign link_state            = state_ff;
endmodule
`default_nettype wire

// *** test/isl_sequencer_assertions.sv ***
// Checker for the link sequencer, watching only its ports.
// Assumes it is bound into isl_sequencer with the same silence parameter.
`timescale 1ns/100ps
`default_nettype none
module isl_sequencer_checker #(
  parameter longint unsigned SILENCE_CYCLES = isl_pkg::SILENCE_CYC
) (
  input wire logic                clk,                   // Clock.
  input wire logic                nrst,                  // Reset, active low.
  input wire logic                rx_frame_valid,        // Frame strobe.
  input wire isl_pkg::isl_frame_t rx_frame_type,         // Frame code.
  input wire logic [7:0]          rx_slot,               // XID slot.
  input wire logic [7:0]          rx_conn_addr,          // Connection address.
  input wire logic                rx_crc_ok,             // Frame good.
  input wire logic                rx_activity,           // Infrared activity.
  input wire logic                tx_reply_valid,        // Reply strobe.
  input wire isl_pkg::isl_reply_t tx_reply_type,         // Reply code.
  input wire logic [7:0]          tx_conn_addr,          // Reply address.
  input wire logic [7:0]          tx_param_rate,         // Advertised rate.
  input wire logic [7:0]          tx_dev_class,          // Advertised class.
  input wire logic                tx_data_valid,         // Host byte out.
  input wire logic                host_cts_n,            // Clear-to-send.
  input wire logic                host_dsr_n,            // Data-set-ready.
  input wire logic                ir_activity_indicator, // Activity level.
  input wire logic                link_baud_9600,        // Fixed rate flag.
  input wire logic [1:0]          link_state             // Sequencer state.
);
  import isl_pkg::*;
  // ----------------------------------------------------------------
  // Silence counters: cycles since the last good frame or activity.
  // ----------------------------------------------------------------
  logic [63:0] quiet_ff, nxt_quiet, dark_ff, nxt_dark;
  logic        good;
  assign good = rx_frame_valid && rx_crc_ok;
  always_comb begin
    nxt_quiet = quiet_ff;
    nxt_dark = dark_ff;
    if (quiet_ff <= SILENCE_CYCLES + 8) nxt_quiet = quiet_ff + 64'h1;
    if (dark_ff <= SILENCE_CYCLES + 8) nxt_dark = dark_ff + 64'h1;
    if (good) nxt_quiet = '0;
    if (rx_activity) nxt_dark = '0;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quiet_ff <= '0;
      dark_ff <= '0;
    end else begin
      quiet_ff <= nxt_quiet;
      dark_ff <= nxt_dark;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  slot_zero_a: assert property (good && rx_frame_type == ISL_FR_XID && rx_slot != 8'h00
    |=> !tx_reply_valid) else $error("Reply to a later timeslot.");
  act_rise_a: assert property (good && rx_frame_type == ISL_FR_XID && link_state == 2'd0
    |=> ir_activity_indicator) else $error("Indicator low after discovery command.");
  bcast_quiet_a: assert property (good && rx_frame_type == ISL_FR_BCAST
    |=> !tx_reply_valid) else $error("Reply to broadcast frame.");
  snrm_ua_a: assert property (good && rx_frame_type == ISL_FR_SNRM && link_state == 2'd1
    |=> tx_reply_valid && tx_reply_type == ISL_RP_UA_PARAM && tx_conn_addr == $past(rx_conn_addr))
    else $error("Link setup answer wrong.");
  data_open_a: assert property (good && rx_frame_type == ISL_FR_DATA_OPEN && link_state == 2'd2
    |=> tx_reply_valid && tx_reply_type == ISL_RP_DATA_OPEN && link_state == 2'd3)
    else $error("Data channel not confirmed.");
  rate_fixed_a: assert property (tx_param_rate == PARAM_RATE_9600 && link_baud_9600
    && tx_dev_class == DEV_CLASS_MODEM) else $error("Advertised parameters wrong.");
  cts_block_a: assert property (link_state != 2'd3 |-> host_cts_n)
    else $error("Host released outside connection.");
  dsr_open_a: assert property (host_dsr_n == (link_state != 2'd3))
    else $error("Data-set-ready does not follow connection.");
  host_hold_a: assert property ($rose(tx_data_valid) |-> $past(link_state) == 2'd3)
    else $error("Host byte forwarded outside connection.");
  close_ack_a: assert property (good && rx_frame_type == ISL_FR_DISC && link_state == 2'd3
    |=> tx_reply_valid && tx_reply_type == ISL_RP_UA_DISC && link_state == 2'd0)
    else $error("Close not confirmed.");
  silence_drop_a: assert property (quiet_ff > SILENCE_CYCLES + 4 |-> link_state == 2'd0)
    else $error("Link held after silence.");
  dark_low_a: assert property (dark_ff > SILENCE_CYCLES + 4 |-> !ir_activity_indicator)
    else $error("Indicator high after silence.");
  cov_stop: cover property (link_state == 2'd3 && host_cts_n);
  cov_close: cover property (tx_reply_valid && tx_reply_type == ISL_RP_UA_DISC);
  cov_dark: cover property ($fell(ir_activity_indicator));
endmodule
bind isl_sequencer isl_sequencer_checker #(.SILENCE_CYCLES(SILENCE_CYCLES))
  i_isl_sequencer_checker (.*);
`default_nettype wire

// *** test/isl_primary_model.sv ***
// Behavioural primary station feeding decoded frames and taking host bytes.
// Assumes the bench calls frame() and sets stall to pace the encoder.
`timescale 1ns/100ps
`default_nettype none
module isl_primary_model #(
  parameter int unsigned XID_GAP = 8
) (
  input  wire logic                clk,            // Clock.
  output logic                     rx_frame_valid, // Frame strobe.
  output isl_pkg::isl_frame_t      rx_frame_type,  // Frame code.
  output logic [7:0]               rx_slot,        // XID slot.
  output logic [7:0]               rx_conn_addr,   // Connection address.
  output logic                     rx_crc_ok,      // Frame good.
  output logic                     rx_activity,    // Infrared activity.
  output logic                     tx_ready,       // Encoder ready.
  input  wire logic                tx_data_valid,  // Host byte out.
  input  wire logic [7:0]          tx_data,        // Host byte value.
  input  wire logic                tx_reply_valid, // Reply strobe.
  input  wire isl_pkg::isl_reply_t tx_reply_type   // Reply code.
);
  import isl_pkg::*;
  // ----------------------------------------------------------------
  // Frame driver and byte collector.
  // ----------------------------------------------------------------
  logic       stall = 1'b1;
  logic [7:0] got_q[$];
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame_type = ISL_FR_OTHER;
    rx_slot = 8'h00;
    rx_conn_addr = 8'h00;
    rx_crc_ok = 1'b0;
    rx_activity = 1'b0;
  end
  assign tx_ready = !stall;
  always @(posedge clk) if (tx_data_valid && tx_ready) got_q.push_back(tx_data);
  // Sends one frame, then watches three cycles for the answer.
  task automatic frame(input isl_frame_t ft, input logic [7:0] sl, input logic [7:0] ad,
                       output logic got, output isl_reply_t rt);
    got = 1'b0;
    rt = ISL_RP_NONE;
    if (ft == ISL_FR_XID) repeat (XID_GAP) @(negedge clk);
    @(negedge clk);
    rx_activity = 1'b1;
    rx_frame_valid = 1'b1;
    rx_frame_type = ft;
    rx_slot = sl;
    rx_conn_addr = ad;
    rx_crc_ok = 1'b1;
    @(negedge clk);
    rx_frame_valid = 1'b0;
    rx_frame_type = ISL_FR_OTHER;
    rx_slot = ~sl;
    rx_conn_addr = ~ad;
    rx_crc_ok = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (tx_reply_valid) begin
        got = 1'b1;
        rt = tx_reply_type;
      end
      @(negedge clk);
    end
    rx_activity = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** test/tb_isl_sequencer.sv ***
// Self-checking bench for the link sequencer.
// Assumes the primary model and the bound checker compile alongside.
`timescale 1ns/100ps
`default_nettype none
module tb_isl_sequencer;
  import isl_pkg::*;
  localparam longint unsigned SIL = 200;
  logic       clk = 1'b0;
  logic       nrst, rx_frame_valid, rx_crc_ok, rx_activity, tx_reply_valid, tx_ready;
  logic       tx_data_valid, host_rx_valid, host_cts_n, host_dsr_n;
  logic       ir_activity_indicator, link_baud_9600, got;
  logic [7:0] rx_slot, rx_conn_addr, tx_conn_addr, tx_param_rate, tx_dev_class;
  logic [7:0] tx_data, host_rx_data;
  logic [1:0] link_state;
  isl_frame_t rx_frame_type;
  isl_reply_t tx_reply_type, rt;
  int         err_total = 0;
  int         comparisons = 0;
  always #2.5 clk = ~clk;
  isl_sequencer #(.SILENCE_CYCLES(SIL)) i_isl_sequencer (.*);
  isl_primary_model i_isl_primary_model (.*);
  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    chk_val(what, {7'h00, exp}, {7'h00, seen});
  endtask
  task automatic send(input isl_frame_t ft, input logic [7:0] sl, input logic [7:0] ad,
                      input logic eg, input isl_reply_t er);
    i_isl_primary_model.frame(ft, sl, ad, got, rt);
    chk_bit("reply strobe", eg, got);
    if (eg) chk_val("reply type", {4'h0, er}, {4'h0, rt});
  endtask
  task automatic host_byte(input logic [7:0] b);
    @(negedge clk);
    host_rx_valid = 1'b1;
    host_rx_data = b;
    @(negedge clk);
    host_rx_valid = 1'b0;
    host_rx_data = ~b;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset();
    chk_bit("cts", 1'b1, host_cts_n);
    chk_bit("dsr", 1'b1, host_dsr_n);
    chk_bit("baud", 1'b1, link_baud_9600);
    chk_val("rate", PARAM_RATE_9600, tx_param_rate);
    chk_val("class", DEV_CLASS_MODEM, tx_dev_class);
    $display("test reset done");
  endtask
  task automatic t_discovery();
    send(ISL_FR_BCAST, 8'h00, 8'h00, 1'b0, ISL_RP_NONE);
    chk_val("state", 8'h00, {6'h00, link_state});
    send(ISL_FR_XID, 8'h00, 8'h00, 1'b1, ISL_RP_XID);
    chk_bit("activity", 1'b1, ir_activity_indicator);
    send(ISL_FR_XID, 8'h01, 8'h00, 1'b0, ISL_RP_NONE);
    chk_val("state", 8'h00, {6'h00, link_state});
    send(ISL_FR_BCAST, 8'h00, 8'h00, 1'b0, ISL_RP_NONE);
    chk_val("state", 8'h01, {6'h00, link_state});
    host_byte(8'h3c);
    chk_bit("byte held", 1'b0, tx_data_valid);
    chk_bit("cts", 1'b1, host_cts_n);
    send(ISL_FR_SNRM, 8'h00, 8'h5a, 1'b1, ISL_RP_UA_PARAM);
    chk_val("address", 8'h5a, tx_conn_addr);
    send(ISL_FR_IAS_QRY, 8'h00, 8'h00, 1'b0, ISL_RP_NONE);
    send(ISL_FR_IAS_OPEN, 8'h00, 8'h00, 1'b1, ISL_RP_IAS_OPEN);
    for (int i = 0; i < 3; i++) send(ISL_FR_IAS_QRY, 8'h00, 8'h00, 1'b1, ISL_RP_IAS_ANS);
    send(ISL_FR_DATA_OPEN, 8'h00, 8'h00, 1'b1, ISL_RP_DATA_OPEN);
    chk_bit("dsr", 1'b0, host_dsr_n);
    chk_bit("cts", 1'b0, host_cts_n);
    send(ISL_FR_DATA, 8'h00, 8'h00, 1'b1, ISL_RP_KEEP);
    $display("test discovery done");
  endtask
  task automatic t_flow();
    for (int i = 0; i < 15; i++) host_byte(8'h40 + 8'(i));
    chk_bit("cts below mark", 1'b0, host_cts_n);
    host_byte(8'h4f);
    host_byte(8'h50);
    @(negedge clk);
    chk_bit("cts at mark", 1'b1, host_cts_n);
    send(ISL_FR_DATA, 8'h00, 8'h00, 1'b1, ISL_RP_DATA);
    i_isl_primary_model.stall = 1'b0;
    for (int n = 0; n < 300 && i_isl_primary_model.got_q.size() < 16; n++) @(negedge clk);
    if (i_isl_primary_model.got_q.size() < 16) begin
      err_total++;
      summarize();
    end
    for (int i = 0; i < 16; i++) chk_val("byte", 8'h40 + 8'(i), i_isl_primary_model.got_q[i]);
    chk_bit("cts drained", 1'b0, host_cts_n);
    send(ISL_FR_STATUS, 8'h00, 8'h00, 1'b1, ISL_RP_KEEP);
    $display("test flow done");
  endtask
  task automatic t_close();
    send(ISL_FR_DISC, 8'h00, 8'h00, 1'b1, ISL_RP_UA_DISC);
    chk_val("state", 8'h00, {6'h00, link_state});
    chk_bit("cts", 1'b1, host_cts_n);
    chk_bit("dsr", 1'b1, host_dsr_n);
    $display("test close done");
  endtask
  task automatic t_silence();
    send(ISL_FR_XID, 8'h00, 8'h00, 1'b1, ISL_RP_XID);
    send(ISL_FR_BCAST, 8'h00, 8'h00, 1'b0, ISL_RP_NONE);
    send(ISL_FR_SNRM, 8'h00, 8'ha5, 1'b1, ISL_RP_UA_PARAM);
    send(ISL_FR_IAS_OPEN, 8'h00, 8'h00, 1'b1, ISL_RP_IAS_OPEN);
    send(ISL_FR_DATA_OPEN, 8'h00, 8'h00, 1'b1, ISL_RP_DATA_OPEN);
    repeat (SIL + 20) @(negedge clk);
    chk_val("state", 8'h00, {6'h00, link_state});
    chk_bit("activity", 1'b0, ir_activity_indicator);
    $display("test silence done");
  endtask
  initial begin
    nrst = 1'b0;
    host_rx_valid = 1'b0;
    host_rx_data = 8'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_discovery();
    t_flow();
    t_close();
    t_silence();
    summarize();
  end
endmodule
`default_nettype wire
